// file: core/sys_ctl_bank.sv
// system control port bank: control, switches, keyboard and printer ports
//
// Contract
// RULE_01 - control bit 0 gates the speaker tone and bit 1 drives speaker data.
// RULE_02 - control bit 3 selects which switch group shows in the low nibble of the status port.
// RULE_03 - control bit 4 low enables parity error reporting, high disables it.
// RULE_04 - control bit 5 low enables io channel check reporting, high disables it.
// RULE_05 - control bit 6 enables the keyboard clock and bit 7 holds the keyboard cleared.
// RULE_06 - with group select low the status port shows the display switches in bits 0 and 1.
// RULE_07 - with group select high it shows coprocessor in bit 1 and memory size in bits 2, 3.
// RULE_08 - status bit 4 is timer counter 2, bit 6 io check and bit 7 parity check.
// RULE_09 - a write to the status port stores coprocessor, memory size and display config.
// RULE_10 - that write keeps the drive count in bit 0 and bits 6 and 7.
// RULE_11 - the printer data, status and control ports are decoded and served.
// RULE_12 - with the floppy strap removed the on-board floppy controller is disabled.
// RULE_13 - a read of the keyboard port returns the last received keyboard byte.
// RULE_14 - the lock port holds parity enable low in bit 0, coprocessor bit 1, lock bit 5.
`timescale 1ns/100ps
module sys_ctl_bank
  import sys_ctl_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  input  wire io_req_t   i_io,
  input  wire pins_t     i_pins,
  output logic [7:0]     o_io_rdata,
  output logic           o_io_rd_ack,
  output sys_ctl_t       o_sys_ctl,
  output cfg_wr_t        o_cfg,
  output lock_ctl_t      o_lock_ctl,
  output logic           o_fdc_en,
  output logic [7:0]     o_prn_data,
  output logic [4:0]     o_prn_ctl
);

  // whole state of the block
  typedef struct packed {
    pins_t      s1;
    pins_t      s2;
    logic       kbd_valid_d1;
    logic [7:0] kbd_byte;
    logic       par_flag;
    logic       ioc_flag;
    sys_ctl_t   ctl;
    cfg_wr_t    cfg;
    lock_ctl_t  lock;
    logic       fdc_en;
    logic [7:0] prn_data;
    logic [4:0] prn_ctl;
    logic [7:0] rdata;
    logic       rd_ack;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [3:0] low_nib;
  logic [7:0] sts_byte;

  // low nibble of the status port and the full status byte
  always_comb begin
    low_nib = 4'h0;
    sts_byte = 8'h00;
    // RULE_02 group select bit
    if (st_q.ctl.grp_sel) begin
      // RULE_07 coprocessor and memory group
      low_nib = {st_q.s2.mem_sw, st_q.s2.copro_sw, 1'b0};
    end else begin
      // RULE_06 display switch group
      low_nib = {2'b00, st_q.s2.disp_sw};
    end
    sts_byte[3:0] = low_nib;
    // RULE_08 timer and error status
    sts_byte[STS_TIMER2_BIT] = st_q.s2.timer2;
    sts_byte[STS_IOC_BIT] = st_q.ioc_flag;
    sts_byte[STS_PARITY_BIT] = st_q.par_flag;
  end

  // next state
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_pins;
    st_d.s2 = st_q.s1;
    st_d.kbd_valid_d1 = st_q.s2.kbd_valid;
    st_d.rd_ack = 1'b0;
    // RULE_12 strap removed disables controller
    st_d.fdc_en = st_q.s2.fdc_strap;

    // RULE_05 clear holds the keyboard byte empty
    if (st_q.ctl.kbd_clear) begin
      st_d.kbd_byte = KBD_RST;
    end else if (st_q.s2.kbd_valid && !st_q.kbd_valid_d1) begin
      // RULE_13 capture byte on valid edge
      st_d.kbd_byte = st_q.s2.kbd_data;
    end

    // RULE_03 parity flag, clear then set
    if (st_q.ctl.par_en_n) begin
      st_d.par_flag = 1'b0;
    end
    if (!st_q.ctl.par_en_n && st_q.s2.par_err) begin
      st_d.par_flag = 1'b1;
    end
    // RULE_04 io check flag, clear then set
    if (st_q.ctl.ioc_en_n) begin
      st_d.ioc_flag = 1'b0;
    end
    if (!st_q.ctl.ioc_en_n && st_q.s2.ioc_err) begin
      st_d.ioc_flag = 1'b1;
    end

    // register writes
    if (i_io.wr) begin
      case (i_io.addr)
        // RULE_01 speaker and control bits stored
        PORT_SYS_CTL: st_d.ctl = sys_ctl_t'(i_io.wdata);
        // RULE_09 configuration write
        // RULE_10 drive count bits kept
        PORT_SW_STATUS: st_d.cfg = cfg_wr_t'(i_io.wdata);
        // RULE_14 lock control write
        PORT_LOCK_CTL: st_d.lock = lock_ctl_t'(i_io.wdata);
        // RULE_11 printer data and control
        PORT_PRN_DATA: st_d.prn_data = i_io.wdata;
        PORT_PRN_CTL: st_d.prn_ctl = i_io.wdata[4:0];
        default: st_d.ctl = st_d.ctl;
      endcase
    end

    // register reads, answered one cycle later
    if (i_io.rd) begin
      st_d.rd_ack = 1'b1;
      case (i_io.addr)
        // RULE_13 keyboard byte read
        PORT_KBD_DATA: st_d.rdata = st_q.kbd_byte;
        PORT_SYS_CTL: st_d.rdata = st_q.ctl;
        PORT_SW_STATUS: st_d.rdata = sts_byte;
        // RULE_11 printer reads
        PORT_PRN_DATA: st_d.rdata = st_q.prn_data;
        PORT_PRN_STATUS: st_d.rdata = {st_q.s2.prn_status, 3'h0};
        PORT_PRN_CTL: st_d.rdata = {3'h0, st_q.prn_ctl};
        default: st_d.rdata = UNMAPPED_RD;
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '0;
      st_q.ctl <= sys_ctl_t'(SYS_CTL_RST);
      st_q.cfg <= cfg_wr_t'(CFG_WR_RST);
      st_q.lock <= lock_ctl_t'(LOCK_CTL_RST);
      st_q.prn_data <= PRN_DATA_RST;
      st_q.prn_ctl <= PRN_CTL_RST;
      st_q.kbd_byte <= KBD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state
  assign o_io_rdata = st_q.rdata;
  assign o_io_rd_ack = st_q.rd_ack;
  assign o_sys_ctl = st_q.ctl;
  assign o_cfg = st_q.cfg;
  assign o_lock_ctl = st_q.lock;
  assign o_fdc_en = st_q.fdc_en;
  assign o_prn_data = st_q.prn_data;
  assign o_prn_ctl = st_q.prn_ctl;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  spk_ctl_write_a: assert property ( // RULE_01
    i_io.wr && i_io.addr == PORT_SYS_CTL |=>
      o_sys_ctl.spk_gate == $past(i_io.wdata[0]) && o_sys_ctl.spk_data == $past(i_io.wdata[1]))
    else $error("speaker bits not taken from control write");

  grp_low_a: assert property ( // RULE_06
    i_io.rd && i_io.addr == PORT_SW_STATUS && !o_sys_ctl.grp_sel |=>
      o_io_rd_ack && o_io_rdata[3:2] == 2'b00 && o_io_rdata[1:0] == $past(st_q.s2.disp_sw))
    else $error("display switch group wrong");

  grp_high_a: assert property ( // RULE_07
    i_io.rd && i_io.addr == PORT_SW_STATUS && o_sys_ctl.grp_sel |=>
      o_io_rdata[0] == 1'b0 && o_io_rdata[3:1] == $past({st_q.s2.mem_sw, st_q.s2.copro_sw}))
    else $error("coprocessor and memory group wrong");

  par_disable_a: assert property ( // RULE_03
    o_sys_ctl.par_en_n [*2] |-> !st_q.par_flag)
    else $error("parity flag set while reporting disabled");

  ioc_catch_a: assert property ( // RULE_04
    !o_sys_ctl.ioc_en_n && st_q.s2.ioc_err |=> st_q.ioc_flag)
    else $error("io check event lost");

  kbd_clear_a: assert property ( // RULE_05
    o_sys_ctl.kbd_clear |=> st_q.kbd_byte == KBD_RST)
    else $error("keyboard byte not held clear");

  cfg_store_a: assert property ( // RULE_09
    i_io.wr && i_io.addr == PORT_SW_STATUS |=> o_cfg == $past(i_io.wdata))
    else $error("configuration write not stored");

  fdd_bits_a: assert property ( // RULE_10
    i_io.wr && i_io.addr == PORT_SW_STATUS |=>
      {o_cfg.fdd_hi, o_cfg.fdd_lo} == $past({i_io.wdata[7:6], i_io.wdata[0]}))
    else $error("drive count bits misplaced");

  status_hi_a: assert property ( // RULE_08
    i_io.rd && i_io.addr == PORT_SW_STATUS |=>
      o_io_rdata[7] == $past(st_q.par_flag) && o_io_rdata[6] == $past(st_q.ioc_flag)
      && o_io_rdata[4] == $past(st_q.s2.timer2))
    else $error("status high bits wrong");

  prn_ctl_a: assert property ( // RULE_11
    i_io.wr && i_io.addr == PORT_PRN_CTL ##1 i_io.rd && i_io.addr == PORT_PRN_CTL |=>
      o_io_rdata == {3'h0, $past(i_io.wdata[4:0], 2)})
    else $error("printer control readback wrong");

  fdc_strap_a: assert property ( // RULE_12
    !i_pins.fdc_strap [*4] |-> !o_fdc_en)
    else $error("floppy controller enabled with strap removed");

  kbd_read_a: assert property ( // RULE_13
    i_io.rd && i_io.addr == PORT_KBD_DATA |=> o_io_rdata == $past(st_q.kbd_byte))
    else $error("keyboard read wrong");

  lock_write_a: assert property ( // RULE_14
    i_io.wr && i_io.addr == PORT_LOCK_CTL |=> o_lock_ctl.lock == $past(i_io.wdata[5])
      && o_lock_ctl.par_en_n == $past(i_io.wdata[0]))
    else $error("lock port bits not stored");

  ctl_bits_a: assert property ( // RULE_02
    i_io.wr && i_io.addr == PORT_SYS_CTL |=> o_sys_ctl.grp_sel == $past(i_io.wdata[3]))
    else $error("group select bit not taken from control write");

  err_enables_a: assert property ( // RULE_03
    i_io.wr && i_io.addr == PORT_SYS_CTL |=>
      o_sys_ctl.par_en_n == $past(i_io.wdata[4])
      && o_sys_ctl.ioc_en_n == $past(i_io.wdata[5]))
    else $error("error report enables not taken from control write");

  kbd_ctl_bits_a: assert property ( // RULE_05
    i_io.wr && i_io.addr == PORT_SYS_CTL |=>
      o_sys_ctl.kbd_clk_en == $past(i_io.wdata[6])
      && o_sys_ctl.kbd_clear == $past(i_io.wdata[7]))
    else $error("keyboard control bits not taken from control write");

  ctl_hold_a: assert property ( // RULE_01
    !(i_io.wr && i_io.addr == PORT_SYS_CTL) |=> $stable(o_sys_ctl))
    else $error("control byte changed without a write");

  ctl_read_a: assert property ( // RULE_01
    i_io.rd && i_io.addr == PORT_SYS_CTL |=> o_io_rdata == $past(o_sys_ctl))
    else $error("control byte readback wrong");

  par_catch_a: assert property ( // RULE_03
    !o_sys_ctl.par_en_n && st_q.s2.par_err |=> st_q.par_flag)
    else $error("parity event lost");

  ioc_disable_a: assert property ( // RULE_04
    o_sys_ctl.ioc_en_n [*2] |-> !st_q.ioc_flag)
    else $error("io check flag set while reporting disabled");

  status_gap_a: assert property ( // RULE_08
    i_io.rd && i_io.addr == PORT_SW_STATUS |=> o_io_rdata[5] == 1'b0)
    else $error("unused status bit not zero");

  cfg_hold_a: assert property ( // RULE_09
    !(i_io.wr && i_io.addr == PORT_SW_STATUS) |=> $stable(o_cfg))
    else $error("configuration changed without a write");

  prn_data_a: assert property ( // RULE_11
    i_io.wr && i_io.addr == PORT_PRN_DATA |=> o_prn_data == $past(i_io.wdata))
    else $error("printer data write not stored");

  prn_status_a: assert property ( // RULE_11
    i_io.rd && i_io.addr == PORT_PRN_STATUS |=>
      o_io_rdata == {$past(st_q.s2.prn_status), 3'h0})
    else $error("printer status read wrong");

  rd_ack_a: assert property ( // RULE_11
    i_io.rd |=> o_io_rd_ack)
    else $error("read not acknowledged");

  rd_ack_only_a: assert property ( // RULE_11
    !i_io.rd |=> !o_io_rd_ack)
    else $error("acknowledge without a read");

  fdc_follow_a: assert property ( // RULE_12
    i_pins.fdc_strap [*4] |-> o_fdc_en)
    else $error("floppy controller disabled with strap installed");

  kbd_hold_a: assert property ( // RULE_13
    !o_sys_ctl.kbd_clear && !(st_q.s2.kbd_valid && !st_q.kbd_valid_d1) |=>
      $stable(st_q.kbd_byte))
    else $error("keyboard byte changed without a new key");

  lock_hold_a: assert property ( // RULE_14
    !(i_io.wr && i_io.addr == PORT_LOCK_CTL) |=> $stable(o_lock_ctl))
    else $error("lock port changed without a write");

  lock_copro_a: assert property ( // RULE_14
    i_io.wr && i_io.addr == PORT_LOCK_CTL |=> o_lock_ctl.copro == $past(i_io.wdata[1]))
    else $error("lock port coprocessor bit not stored");

  kbd_capture_c: cover property (st_q.s2.kbd_valid && !st_q.kbd_valid_d1 && !o_sys_ctl.kbd_clear);
  parity_event_c: cover property (!st_q.par_flag ##1 st_q.par_flag);
  grp_toggle_c: cover property (!o_sys_ctl.grp_sel ##[1:20] o_sys_ctl.grp_sel);
  unmapped_rd_c: cover property (o_io_rd_ack && o_io_rdata == UNMAPPED_RD);
  prn_wr_rd_c: cover property (i_io.wr && i_io.addr == PORT_PRN_CTL ##1 i_io.rd);
endmodule

// file: inc/sys_ctl_pkg.sv
// constants and carriers for the system control port bank
package sys_ctl_pkg;
  // io port offsets
  localparam logic [15:0] PORT_KBD_DATA   = 16'h0060;
  localparam logic [15:0] PORT_SYS_CTL    = 16'h0061;
  localparam logic [15:0] PORT_SW_STATUS  = 16'h0062;
  localparam logic [15:0] PORT_LOCK_CTL   = 16'h0063;
  localparam logic [15:0] PORT_PRN_DATA   = 16'h0378;
  localparam logic [15:0] PORT_PRN_STATUS = 16'h0379;
  localparam logic [15:0] PORT_PRN_CTL    = 16'h037A;
  // field positions in the switch and error status byte
  localparam int STS_TIMER2_BIT = 4;
  localparam int STS_IOC_BIT    = 6;
  localparam int STS_PARITY_BIT = 7;
  // reset values and the unmapped read value
  localparam logic [7:0] SYS_CTL_RST  = 8'h30;
  localparam logic [7:0] CFG_WR_RST   = 8'h00;
  localparam logic [7:0] LOCK_CTL_RST = 8'h01;
  localparam logic [7:0] PRN_DATA_RST = 8'h00;
  localparam logic [4:0] PRN_CTL_RST  = 5'h00;
  localparam logic [7:0] KBD_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'hFF;

  // system control byte, msb first
  typedef struct packed {
    logic kbd_clear;
    logic kbd_clk_en;
    logic ioc_en_n;
    logic par_en_n;
    logic grp_sel;
    logic spare;
    logic spk_data;
    logic spk_gate;
  } sys_ctl_t;

  // configuration byte written to the status port
  typedef struct packed {
    logic [1:0] fdd_hi;
    logic [1:0] disp_cfg;
    logic [1:0] mem_size;
    logic       copro;
    logic       fdd_lo;
  } cfg_wr_t;

  // parity and lock control byte
  typedef struct packed {
    logic [1:0] spare_hi;
    logic       lock;
    logic [2:0] spare_mid;
    logic       copro;
    logic       par_en_n;
  } lock_ctl_t;

  // io request from the host bus
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } io_req_t;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic [7:0] kbd_data;
    logic       kbd_valid;
    logic       timer2;
    logic       par_err;
    logic       ioc_err;
    logic [1:0] disp_sw;
    logic       copro_sw;
    logic [1:0] mem_sw;
    logic       fdc_strap;
    logic [4:0] prn_status;
  } pins_t;
endpackage

// file: verification/far_side_model.sv
// peripheral side model: keyboard, switches, timer, printer status, strap
`timescale 1ns/100ps
module far_side_model
  import sys_ctl_pkg::*;
(
  input  wire logic i_clk,
  output pins_t     o_pins
);
  pins_t p;
  assign o_pins = p;
  // quiet pins, strap installed
  initial begin
    p = '0;
    p.fdc_strap = 1'b1;
  end
  task automatic send_key(input logic [7:0] b);
    @(negedge i_clk);
    p.kbd_data = b;
    @(negedge i_clk);
    p.kbd_valid = 1'b1;
    repeat (6) @(negedge i_clk);
    p.kbd_valid = 1'b0;
    p.kbd_data = ~b; // released data no longer shows the byte
  endtask
endmodule

// file: verification/system_control_port_bank_tb_top.sv
// testbench: port access sequences against the control port bank
`timescale 1ns/100ps
module system_control_port_bank_tb_top
  import sys_ctl_pkg::*;
;
  logic      i_clk;
  logic      i_rst;
  io_req_t   io;
  pins_t     pins;
  logic [7:0] rdata;
  logic      ack;
  sys_ctl_t  sc;
  cfg_wr_t   cfg;
  lock_ctl_t lk;
  logic      fdc;
  logic [7:0] pd;
  logic [4:0] pc;
  int        mismatches;
  int        checks_done;

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  far_side_model far_side_model_i (.i_clk(i_clk), .o_pins(pins));
  sys_ctl_bank sys_ctl_bank_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_io(io), .i_pins(pins),
    .o_io_rdata(rdata), .o_io_rd_ack(ack), .o_sys_ctl(sc), .o_cfg(cfg),
    .o_lock_ctl(lk), .o_fdc_en(fdc), .o_prn_data(pd), .o_prn_ctl(pc)
  );

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    io.addr = a;
    io.wdata = d;
    io.wr = 1'b1;
    @(negedge i_clk);
    io.wr = 1'b0;
  endtask
  // one-cycle read strobe, answer one cycle later
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    io.addr = a;
    io.rd = 1'b1;
    @(negedge i_clk);
    io.rd = 1'b0;
    chk({7'h00, ack}, 8'h01);
    chk(rdata, exp);
  endtask
  // write then read in back-to-back cycles
  task automatic wr_rd_chk(input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(negedge i_clk);
    io.addr = a;
    io.wdata = d;
    io.wr = 1'b1;
    @(negedge i_clk);
    io.wr = 1'b0;
    io.rd = 1'b1;
    @(negedge i_clk);
    io.rd = 1'b0;
    chk({7'h00, ack}, 8'h01);
    chk(rdata, exp);
  endtask
  // pins pass two flops
  task automatic settle();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end

  // test sequence
  initial begin
    i_rst = 1'b1;
    io = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    chk(sc, SYS_CTL_RST);
    chk(lk, LOCK_CTL_RST);
    rd_chk(PORT_SYS_CTL, 8'h30);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(PORT_SYS_CTL, 8'h01 << i);
      chk(sc, 8'h01 << i);
      rd_chk(PORT_SYS_CTL, 8'h01 << i);
    end
    $display("test control done");
    far_side_model_i.p.disp_sw = 2'b10;
    far_side_model_i.p.copro_sw = 1'b1;
    far_side_model_i.p.mem_sw = 2'b01;
    far_side_model_i.p.timer2 = 1'b1;
    far_side_model_i.p.par_err = 1'b1;
    far_side_model_i.p.ioc_err = 1'b1;
    wr(PORT_SYS_CTL, 8'h30);
    settle();
    rd_chk(PORT_SW_STATUS, 8'h12);
    wr(PORT_SYS_CTL, 8'h38);
    rd_chk(PORT_SW_STATUS, 8'h16);
    far_side_model_i.p.par_err = 1'b0;
    far_side_model_i.p.ioc_err = 1'b0;
    $display("test switches done");
    for (int i = 0; i < 2; i++) begin
      wr(PORT_SYS_CTL, (i == 0) ? 8'h20 : 8'h10);
      if (i == 0)
        far_side_model_i.p.par_err = 1'b1;
      else
        far_side_model_i.p.ioc_err = 1'b1;
      settle();
      far_side_model_i.p.par_err = 1'b0;
      far_side_model_i.p.ioc_err = 1'b0;
      settle();
      rd_chk(PORT_SW_STATUS, (i == 0) ? 8'h92 : 8'h52);
      wr(PORT_SYS_CTL, 8'h30);
      rd_chk(PORT_SW_STATUS, 8'h12);
    end
    $display("test error flags done");
    wr(PORT_SW_STATUS, 8'hA5);
    chk(cfg, 8'hA5);
    wr(PORT_SW_STATUS, 8'h5A);
    chk(cfg, 8'h5A);
    rd_chk(PORT_SW_STATUS, 8'h12);
    wr(PORT_LOCK_CTL, 8'h22);
    chk(lk, 8'h22);
    $display("test config done");
    far_side_model_i.send_key(8'h5A);
    rd_chk(PORT_KBD_DATA, 8'h5A);
    wr(PORT_KBD_DATA, 8'h00);
    rd_chk(PORT_KBD_DATA, 8'h5A);
    wr(PORT_SYS_CTL, 8'hB0);
    rd_chk(PORT_KBD_DATA, 8'h00);
    wr(PORT_SYS_CTL, 8'h30);
    $display("test keyboard done");
    wr(PORT_PRN_DATA, 8'hC3);
    chk(pd, 8'hC3);
    wr(PORT_PRN_CTL, 8'h15);
    chk({3'b000, pc}, 8'h15);
    rd_chk(PORT_PRN_CTL, 8'h15);
    rd_chk(PORT_PRN_DATA, 8'hC3);
    wr_rd_chk(PORT_PRN_CTL, 8'h0A, 8'h0A);
    chk({3'b000, pc}, 8'h0A);
    far_side_model_i.p.prn_status = 5'h13;
    settle();
    rd_chk(PORT_PRN_STATUS, 8'h98);
    $display("test printer done");
    chk({7'h00, fdc}, 8'h01);
    far_side_model_i.p.fdc_strap = 1'b0;
    settle();
    chk({7'h00, fdc}, 8'h00);
    rd_chk(16'h0064, UNMAPPED_RD);
    $display("test strap and unmapped done");
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    chk(sc, SYS_CTL_RST);
    chk(cfg, CFG_WR_RST);
    chk(lk, LOCK_CTL_RST);
    chk(pd, PRN_DATA_RST);
    rd_chk(PORT_KBD_DATA, KBD_RST);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
